// [capture_pkg.sv]
// constants, types and register map for the input capture channel
// assumes an apb master on pclk and timer counts on the same clock
package capture_pkg;
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] buf_off = 12'h004;
  localparam logic [11:0] status_off = 12'h008;
  localparam logic [11:0] mask_off = 12'h00c;
  localparam int idle_bit = 13;
  localparam int tsel_bit = 7;
  localparam int pace_lsb = 5;
  localparam int ovf_bit = 4;
  localparam int bne_bit = 3;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [15:0] ctrl_wmask = 16'h20e7;
  localparam int fifo_depth = 4;
  localparam logic [3:0] presc4 = 4'h3;
  localparam logic [3:0] presc16 = 4'hf;
  localparam logic [2:0] evt_reset = 3'h0;

  typedef enum logic [2:0] {
    mode_off = 3'b000,
    mode_both = 3'b001,
    mode_fall = 3'b010,
    mode_rise = 3'b011,
    mode_rise4 = 3'b100,
    mode_rise16 = 3'b101,
    mode_unused = 3'b110,
    mode_wake = 3'b111
  } capture_mode_t;

  // event status bits: capture interrupt, overflow, wake
  typedef struct packed {
    logic wake;
    logic overflow;
    logic capture;
  } events_t;

  typedef struct packed {
    logic sleep;
    logic idle;
  } power_t;
endpackage : capture_pkg

// [input_capture_channel.sv]
// one input capture channel with an apb register slave
// a device holds up to eight of these, each with its own pin and fifo
// assumes timer counts and power state come from logic on pclk
`timescale 1ns/1ps
module input_capture_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] second_timer_count,
  input wire capture_pkg::power_t power,
  output logic irq,
  output logic wake_request
);
  import capture_pkg::*;

  logic [15:0] ctrl;
  logic [2:0] pin_sync;
  logic pin_prev;
  logic [3:0] presc;
  logic [1:0] pace_cnt;
  logic [15:0] fifo [fifo_depth];
  logic [1:0] rd_ptr;
  logic [1:0] wr_ptr;
  logic [2:0] count;
  logic overflow;
  events_t status;
  events_t mask;
  logic [2:0] last_mode;

  logic setup_ok;
  logic wr_en;
  logic rd_en;
  logic pop;
  logic running;
  logic rise;
  logic fall;
  logic capture_evt;
  logic pace_hit;
  logic wake_evt;
  logic [15:0] stamp;
  capture_mode_t mode;
  events_t set_evt;
  logic [31:0] next_prdata;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = p + 2'd1;
  endfunction : ptr_inc

  // apb decode, zero wait states
  assign setup_ok = psel && !penable;
  assign wr_en = clk_en && psel && penable && pwrite && pready;
  assign rd_en = clk_en && psel && penable && !pwrite && pready;
  assign pop = rd_en && (paddr == buf_off) && (count != 3'd0);
  assign mode = capture_mode_t'(ctrl[2:0]);

  // halted in idle when idle-stop set
  assign running = !(power.idle && ctrl[idle_bit]);

  // stable once second and third stages agree
  assign rise = (pin_sync[2] == pin_sync[1]) && pin_sync[2] && !pin_prev;
  assign fall = (pin_sync[2] == pin_sync[1]) && !pin_sync[2] && pin_prev;

  assign stamp = ctrl[tsel_bit] ? first_timer_count : second_timer_count;

  // qualifying event per mode
  always_comb begin
    capture_evt = 1'b0;
    case (mode)
      mode_both: capture_evt = rise || fall;
      mode_fall: capture_evt = fall;
      mode_rise: capture_evt = rise;
      mode_rise4: capture_evt = rise && (presc[1:0] == presc4[1:0]);
      mode_rise16: capture_evt = rise && (presc == presc16);
      mode_off, mode_unused: capture_evt = 1'b0;
      default: capture_evt = 1'b0;
    endcase
    capture_evt = capture_evt && running;
  end

  // pacing: both-edge mode interrupts every capture
  assign pace_hit = capture_evt &&
    ((mode == mode_both) || (pace_cnt == ctrl[pace_lsb +: 2]));

  assign wake_evt = (mode == mode_wake) && rise && (power.sleep || power.idle);

  always_comb begin
    set_evt.capture = pace_hit;
    set_evt.overflow = capture_evt && (count == 3'(fifo_depth));
    set_evt.wake = wake_evt;
  end

  // pin synchroniser, three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 3'b000;
      pin_prev <= 1'b0;
    end else if (clk_en) begin
      pin_sync <= {pin_sync[1:0], capture_pin};
      if (pin_sync[2] == pin_sync[1]) pin_prev <= pin_sync[2];
    end
  end

  // edge prescaler, cleared when mode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 4'h0;
      last_mode <= evt_reset;
    end else if (clk_en) begin
      last_mode <= ctrl[2:0];
      if (last_mode != ctrl[2:0]) presc <= 4'h0;
      else if (rise && running) presc <= presc + 4'h1;
    end
  end

  // capture pacing counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_cnt <= 2'b00;
    end else if (clk_en) begin
      if (last_mode != ctrl[2:0]) pace_cnt <= 2'b00;
      else if (pace_hit) pace_cnt <= 2'b00;
      else if (capture_evt) pace_cnt <= pace_cnt + 2'b01;
    end
  end

  // four word fifo; full drops new value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 2'b00;
      rd_ptr <= 2'b00;
      count <= 3'd0;
    end else if (clk_en) begin
      if (capture_evt && count != 3'(fifo_depth)) wr_ptr <= ptr_inc(wr_ptr);
      if (pop) rd_ptr <= ptr_inc(rd_ptr);
      case ({capture_evt && count != 3'(fifo_depth), pop})
        2'b10: count <= count + 3'd1;
        2'b01: count <= count - 3'd1;
        default: count <= count;
      endcase
    end
  end

  // fifo storage
  always_ff @(posedge pclk) begin
    if (clk_en && capture_evt && count != 3'(fifo_depth)) fifo[wr_ptr] <= stamp;
  end

  // overflow: set on full capture, cleared by hardware once drained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) overflow <= 1'b0;
    else if (clk_en) begin
      if (set_evt.overflow) overflow <= 1'b1;
      else if (count == 3'd0 || mode == mode_off) overflow <= 1'b0;
    end
  end

  // control register, status bits are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl <= ctrl_reset;
    else if (wr_en && paddr == ctrl_off) ctrl <= pwdata[15:0] & ctrl_wmask;
  end

  // sticky status, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= events_t'(evt_reset);
      mask <= events_t'(evt_reset);
    end else if (clk_en) begin
      if (wr_en && paddr == status_off) status <= (status & ~events_t'(pwdata[2:0])) | set_evt;
      else status <= status | set_evt;
      if (wr_en && paddr == mask_off) mask <= events_t'(pwdata[2:0]);
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ctrl_off: begin
        next_prdata[15:0] = ctrl;
        next_prdata[ovf_bit] = overflow;
        next_prdata[bne_bit] = (count != 3'd0);
      end
      buf_off: next_prdata[15:0] = (count != 3'd0) ? fifo[rd_ptr] : 16'h0000;
      status_off: next_prdata[2:0] = status;
      mask_off: next_prdata[2:0] = mask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // apb response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= setup_ok;
      pslverr <= setup_ok && !(paddr == ctrl_off || paddr == buf_off ||
                 paddr == status_off || paddr == mask_off);
      if (setup_ok && !pwrite) prdata <= next_prdata;
    end
  end

  // interrupt and wake outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake_request <= 1'b0;
    end else if (clk_en) begin
      irq <= |((status | set_evt) & mask);
      wake_request <= wake_evt || (capture_evt && (power.sleep || power.idle));
    end
  end
endmodule : input_capture_channel

// [input_capture_channel_assertions.sv]
// checker for the capture channel bus and event outputs
// assumes it is bound onto the channel ports
`timescale 1ns/1ps
module input_capture_channel_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic wake_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers one cycle after setup, once
  AST_RDY_SETUP: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_RDY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  // places at 0x010 and up are refused, word-aligned ones below are not
  AST_ERR_MAP: assert property (psel && !penable && clk_en && paddr[11:4] != 0 |=> pslverr)
    else $error("unmapped address not refused");
  AST_OK_MAP: assert property (psel && !penable && clk_en && paddr[11:4] == 0 &&
    paddr[1:0] == 0 |=> !pslverr)
    else $error("mapped address refused");
  AST_ERR_DATA: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused access with data");
  AST_UPPER: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
    else $error("wake longer than one cycle");
  AST_RST_QUIET: assert property ($rose(presetn) |-> !irq && !wake_request && !pready)
    else $error("output active after reset");
  // main scenarios
  cover property (irq);
  cover property (wake_request);
  cover property (pslverr);
endmodule : input_capture_channel_assertions

// [input_capture_channel_tb_top.sv]
// self-checking bench for the input capture channel
// assumes the pin model drives the pin and timer counts stand still per test
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module input_capture_channel_tb_top;
  import capture_pkg::*;
  typedef struct {logic [2:0] m; logic ts; logic [1:0] pc; int n; int caps; logic fl;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic wake_request, capture_pin, rerr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic [15:0] t1 = 0, t2 = 0;
  power_t power = '0;
  int error_cnt = 0, checked = 0, cyc = 0, wakes = 0;
  // rows with pacing 00 raise the capture flag on every capture, as dma use needs
  row_t rows [10] = '{'{mode_rise, 1, 0, 2, 2, 1}, '{mode_fall, 0, 0, 2, 2, 1},
    '{mode_rise, 0, 3, 3, 3, 0}, '{mode_both, 1, 3, 1, 2, 1}, '{mode_rise, 1, 1, 2, 2, 1},
    '{mode_rise4, 0, 0, 4, 1, 1}, '{mode_rise, 0, 2, 3, 3, 1}, '{mode_rise16, 1, 0, 16, 1, 1},
    '{mode_off, 1, 0, 3, 0, 0}, '{mode_unused, 1, 0, 3, 0, 0}};
  input_capture_channel dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin), .first_timer_count(t1),
    .second_timer_count(t2), .power(power), .irq(irq), .wake_request(wake_request));
  pin_source pin (.pclk(pclk), .capture_pin(capture_pin));
  initial forever #10 pclk = ~pclk;
  // cycle ceiling and wake pulse count
  always @(posedge pclk) begin
    cyc++;
    if (wake_request === 1'b1) wakes++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task run_row(input row_t r, input int i);
    logic [15:0] v;
    v = r.ts ? 16'h1100 + i[15:0] : 16'h2200 + i[15:0];
    t1 <= 16'h1100 + i[15:0];
    t2 <= 16'h2200 + i[15:0];
    apb(1'b1, ctrl_off, {24'h0, r.ts, r.pc, 2'b0, r.m});
    pin.pulses(r.n);
    apb(1'b0, status_off, 32'h0);
    `CHK("capture flag", r.fl, rdata[0])
    repeat (r.caps) begin
      apb(1'b0, buf_off, 32'h0);
      `CHK("value", v, rdata[15:0])
    end
    apb(1'b0, ctrl_off, 32'h0);
    `CHK("not empty", 1'b0, rdata[bne_bit])
    apb(1'b1, status_off, 32'h7);
    $display("row %0d done", i);
  endtask : run_row
  task final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // reset, table rows, then hand-written cases
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctrl_off, 32'h0);
    `CHK("ctrl reset", 32'h0, rdata)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("refused", 1'b1, rerr)
    for (int i = 0; i < 10; i++) run_row(rows[i], i);
    apb(1'b1, ctrl_off, 32'h83);
    pin.pulses(5);
    apb(1'b1, ctrl_off, 32'h83);
    apb(1'b0, ctrl_off, 32'h0);
    `CHK("overflow", 2'b11, rdata[4:3])
    repeat (4) apb(1'b0, buf_off, 32'h0);
    apb(1'b0, ctrl_off, 32'h0);
    `CHK("drained", 2'b00, rdata[4:3])
    apb(1'b1, mask_off, 32'h1);
    pin.pulses(1);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, status_off, 32'h7);
    apb(1'b0, buf_off, 32'h0);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    power <= 2'b01;
    apb(1'b1, ctrl_off, 32'h2003);
    pin.pulses(2);
    apb(1'b0, ctrl_off, 32'h0);
    `CHK("idle halt", 1'b0, rdata[bne_bit])
    power <= 2'b10;
    apb(1'b1, ctrl_off, 32'h7);
    pin.pulses(2);
    `CHK("wakes", 2, wakes)
    apb(1'b0, status_off, 32'h0);
    `CHK("wake flag", 1'b1, rdata[2])
    $display("hand cases done");
    final_report;
  end
endmodule : input_capture_channel_tb_top
bind input_capture_channel input_capture_channel_assertions chk (.*);

// [pin_source.sv]
// pin model: an outside logic signal driving the capture pin
// assumes pclk is the channel clock
`timescale 1ns/1ps
module pin_source (
  input wire logic pclk,
  output logic capture_pin
);
  initial capture_pin = 1'b0;
  // each level held six cycles so the synchroniser sees every edge
  task pulses(input int n);
    repeat (n) begin
      repeat (6) @(posedge pclk);
      capture_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      capture_pin <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask : pulses
endmodule : pin_source
